/* pkg/uoe_pkg.sv */
// Purpose: Constants for the OUT endpoint buffer configuration block
// Assumes: Classic Wishbone slave, 32-bit data, one register per aligned word
// Notes: Register offsets are byte addresses

package uoe_pkg;

  // ******************************
  // Register map
  // ******************************
  localparam logic [7:0] UOE_ADR_BSIZE = 8'h00;
  localparam logic [7:0] UOE_ADR_XBASE = 8'h04;
  localparam logic [7:0] UOE_ADR_CNF = 8'h08;
  localparam logic [7:0] UOE_ADR_XCNT = 8'h0C;
  localparam logic [7:0] UOE_ADR_YBASE = 8'h10;
  localparam logic [7:0] UOE_ADR_YCNT = 8'h14;
  localparam logic [7:0] UOE_ADR_IRQ_STAT = 8'h18;
  localparam logic [7:0] UOE_ADR_IRQ_MASK = 8'h1C;

  // ******************************
  // Configuration byte fields
  // ******************************
  localparam int UOE_CNF_EN = 7;
  localparam int UOE_CNF_ISO = 6;
  localparam int UOE_CNF_TOG = 5;
  localparam int UOE_CNF_TWO_BUFFER_SELECT = 4;
  localparam int UOE_CNF_STALL = 3;
  localparam int UOE_CNF_IE = 2;
  localparam int UOE_CNT_NAK = 7;

  // Status bits: 0 X packet, 1 Y packet, 2 non-iso overflow
  localparam int UOE_IRQ_X = 0;
  localparam int UOE_IRQ_Y = 1;
  localparam int UOE_IRQ_OVF = 2;
  localparam int UOE_IRQ_W = 3;

  // ******************************
  // Geometry and reset values
  // ******************************
  localparam int UOE_ADDR_W = 11;
  localparam int UOE_UNIT_SHIFT = 3;
  localparam logic [7:0] UOE_RST_BYTE = 8'h00;
  localparam int UOE_MEM_DEPTH = 2048;

  // Handshake answer codes
  typedef enum logic [1:0] {UOE_HS_ACK, UOE_HS_NAK, UOE_HS_STALL, UOE_HS_NONE} uoe_hs_t;

endpackage : uoe_pkg

/* logic/uoe_mem.sv */
// Purpose: Endpoint packet memory, byte wide, registered read
// Assumes: One write port from the receive path, one read port for firmware
// Notes: Depth covers the full 11-bit address space
`timescale 1ns/1ps

module uoe_mem (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [uoe_pkg::UOE_ADDR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [uoe_pkg::UOE_ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [uoe_pkg::UOE_MEM_DEPTH];

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : uoe_mem

/* logic/uoe_wb_slave.sv */
// Purpose: Classic Wishbone slave handshake with one-cycle registered ack
// Assumes: Master holds its request until ack
// Notes: Ack drops the cycle after it is given, even if stb stays high
`timescale 1ns/1ps

module uoe_wb_slave (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  output logic wb_ack_o,
  output logic wr_fire,
  output logic rd_fire
);

  logic ack_q;
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req;
    end
  end

  assign wb_ack_o = ack_q;
  // Effects happen on the acked edge only
  assign wr_fire = req & wb_we_i;
  assign rd_fire = req & ~wb_we_i;

endmodule : uoe_wb_slave

/* logic/uoe_out_ep.sv */
// Purpose: One USB OUT endpoint: buffer size, base addresses, configuration,
//   receive placement into packet memory and handshake choice
// Assumes: Packet decoder supplies byte strobes, the DATA1 PID flag and end of packet
// Notes: Registers over classic Wishbone; one level interrupt
// Behaviour
// (R1) Buffer size is size field times eight
// (R2) X and Y buffers share one size
// (R3) Isochronous uses size as one circular buffer
// (R4) X start is 11 bits, upper from register
// (R5) Low three start bits forced to zero
// (R6) Firmware sets enable bit to activate endpoint
// (R7) Bit 6 selects isochronous or other type
// (R8) Toggle flips after good packet, PID matched
// (R9) Configuration bits read per endpoint type
// (R10) Double buffer alternates X and Y
// (R11) Stall answers STALL except setup stages
// (R12) Good packet sets NAK flag, then NAK
// (R13) Firmware sets interrupt enable bit for interrupts
// (R14) Write address is start plus offset, bounded
// (R15) Isochronous pointer wraps at buffer length
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

module uoe_out_ep (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_start,
  input wire logic rx_setup,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_good,
  input wire logic rx_pid_data1,
  output logic [1:0] hs_code,
  output logic hs_valid,
  input wire logic [uoe_pkg::UOE_ADDR_W-1:0] fw_rd_addr,
  output logic [7:0] fw_rd_data,
  output logic irq
);

  // ******************************
  // Register bus
  // ******************************
  logic wr_fire;
  logic rd_fire;

  uoe_wb_slave u_bus (
    .clk_sys(clk_sys),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o),
    .wr_fire(wr_fire),
    .rd_fire(rd_fire)
  );

  logic [7:0] bsize_q;
  logic [7:0] xbase_q;
  logic [7:0] ybase_q;
  logic [7:0] cnf_q;
  logic [7:0] cnf_d;
  logic [7:0] xcnt_q;
  logic [7:0] xcnt_d;
  logic [7:0] ycnt_q;
  logic [7:0] ycnt_d;
  logic [2:0] stat_q;
  logic [2:0] stat_d;
  logic [2:0] mask_q;
  logic [31:0] rdata_q;

  wire lane0 = wb_sel_i[0];
  wire wr_bsize = wr_fire & lane0 & (wb_adr_i == uoe_pkg::UOE_ADR_BSIZE);
  wire wr_xbase = wr_fire & lane0 & (wb_adr_i == uoe_pkg::UOE_ADR_XBASE);
  wire wr_cnf = wr_fire & lane0 & (wb_adr_i == uoe_pkg::UOE_ADR_CNF);
  wire wr_xcnt = wr_fire & lane0 & (wb_adr_i == uoe_pkg::UOE_ADR_XCNT);
  wire wr_ybase = wr_fire & lane0 & (wb_adr_i == uoe_pkg::UOE_ADR_YBASE);
  wire wr_ycnt = wr_fire & lane0 & (wb_adr_i == uoe_pkg::UOE_ADR_YCNT);
  wire wr_mask = wr_fire & lane0 & (wb_adr_i == uoe_pkg::UOE_ADR_IRQ_MASK);
  wire rd_stat = rd_fire & (wb_adr_i == uoe_pkg::UOE_ADR_IRQ_STAT);
  wire [7:0] wb_byte = wb_dat_i[7:0];

  // ******************************
  // Configuration decode
  // ******************************
  wire ep_en = cnf_q[uoe_pkg::UOE_CNF_EN]; // R6
  wire ep_iso = cnf_q[uoe_pkg::UOE_CNF_ISO]; // R7
  // Bits 5..2 mean toggle/two_buffer_select/stall/ie only on non-iso endpoints
  wire ep_tog = ~ep_iso & cnf_q[uoe_pkg::UOE_CNF_TOG]; // R9
  wire ep_two_buffer_select = ~ep_iso & cnf_q[uoe_pkg::UOE_CNF_TWO_BUFFER_SELECT]; // R9 R10
  wire ep_stall = ~ep_iso & cnf_q[uoe_pkg::UOE_CNF_STALL]; // R9
  wire ep_ie = ~ep_iso & cnf_q[uoe_pkg::UOE_CNF_IE]; // R9 R13

  // Size in bytes, same for X and Y; 255*8 fits in 11 bits, widened to 12 to match the offsets
  wire [11:0] buf_len = {1'b0, bsize_q, 3'b000}; // R1 R2 R3
  wire [10:0] x_start = {xbase_q, 3'b000}; // R4 R5
  wire [10:0] y_start = {ybase_q, 3'b000}; // R5

  // ******************************
  // Receive path
  // ******************************
  logic use_y_q;
  logic sel_y_q;
  logic [11:0] off_q;
  logic [11:0] iso_ptr_q;
  logic busy_q;
  logic drop_q;

  wire x_nak = xcnt_q[uoe_pkg::UOE_CNT_NAK];
  wire y_nak = ycnt_q[uoe_pkg::UOE_CNT_NAK];
  wire tgt_y = ep_two_buffer_select & use_y_q; // R10
  wire tgt_full = tgt_y ? y_nak : x_nak;
  // Non-iso endpoints refuse data while the target holds a packet
  wire refuse_nak = ~ep_iso & tgt_full; // R12
  wire refuse_stall = ep_stall & ~rx_setup; // R11
  wire accept = ep_en & ~refuse_stall & ~refuse_nak;
  wire pid_ok = ep_iso | (rx_pid_data1 == ep_tog);

  wire [10:0] base_now = sel_y_q ? y_start : x_start;
  wire [11:0] wr_off = ep_iso ? iso_ptr_q : off_q;
  wire in_range = wr_off < buf_len; // R14
  wire mem_we = busy_q & ~drop_q & rx_valid & in_range;
  wire [10:0] mem_addr = base_now + wr_off[10:0]; // R14
  wire [11:0] iso_next = iso_ptr_q + 12'h001;
  // Overflow: non-iso packet longer than the programmed buffer
  wire ovf_evt = busy_q & ~drop_q & rx_valid & ~in_range & ~ep_iso;
  // Iso overflow: one packet longer than the whole ring overwrites itself
  wire iso_ovf = busy_q & ~drop_q & rx_valid & ep_iso & (off_q >= buf_len); // R9
  wire pkt_done = busy_q & ~drop_q & rx_end & rx_good & pid_ok;
  wire [6:0] cnt_val = off_q[6:0];

  uoe_mem u_mem (
    .clk_sys(clk_sys),
    .wr_en(mem_we),
    .wr_addr(mem_addr),
    .wr_data(rx_data),
    .rd_addr(fw_rd_addr),
    .rd_data(fw_rd_data)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      drop_q <= 1'b0;
      sel_y_q <= 1'b0;
      off_q <= 12'h000;
    end
    else if (rx_start)
    begin
      busy_q <= 1'b1;
      drop_q <= ~accept;
      sel_y_q <= tgt_y;
      off_q <= 12'h000;
    end
    else if (busy_q & rx_end)
    begin
      busy_q <= 1'b0;
    end
    else if (mem_we | (busy_q & rx_valid))
    begin
      off_q <= off_q + 12'h001;
    end
  end

  // Circular pointer persists across iso packets
  always_ff @(posedge clk_sys)
  begin
    if (rst | wr_bsize)
    begin
      iso_ptr_q <= 12'h000;
    end
    else if (mem_we & ep_iso)
    begin
      iso_ptr_q <= (iso_next >= buf_len) ? 12'h000 : iso_next; // R15
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      use_y_q <= 1'b0;
    end
    else if (~ep_two_buffer_select)
    begin
      use_y_q <= 1'b0;
    end
    else if (pkt_done)
    begin
      use_y_q <= ~use_y_q; // R10
    end
  end

  // Handshake: one-cycle pulse at non-iso packet end
  assign hs_valid = busy_q & rx_end & ~ep_iso;
  assign hs_code = ~ep_en ? uoe_pkg::UOE_HS_NONE :
                   refuse_stall ? uoe_pkg::UOE_HS_STALL : // R11
                   drop_q ? uoe_pkg::UOE_HS_NAK : // R12
                   pkt_done ? uoe_pkg::UOE_HS_ACK : uoe_pkg::UOE_HS_NONE;

  // ******************************
  // Registers with hardware updates
  // ******************************
  always_comb
  begin
    cnf_d = wr_cnf ? wb_byte : cnf_q;
    if (pkt_done & ~ep_iso)
    begin
      cnf_d[uoe_pkg::UOE_CNF_TOG] = ~cnf_q[uoe_pkg::UOE_CNF_TOG]; // R8
    end
    if (iso_ovf)
    begin
      cnf_d[uoe_pkg::UOE_CNF_TOG] = 1'b1;
    end
    xcnt_d = wr_xcnt ? wb_byte : xcnt_q;
    ycnt_d = wr_ycnt ? wb_byte : ycnt_q;
    // Hardware set wins over a firmware clear in the same cycle
    if (pkt_done & ~sel_y_q)
    begin
      xcnt_d = {1'b1, cnt_val}; // R12
    end
    if (pkt_done & sel_y_q)
    begin
      ycnt_d = {1'b1, cnt_val}; // R12
    end
    stat_d = rd_stat ? 3'b000 : stat_q;
    stat_d[uoe_pkg::UOE_IRQ_X] = stat_d[uoe_pkg::UOE_IRQ_X] | (pkt_done & ~sel_y_q);
    stat_d[uoe_pkg::UOE_IRQ_Y] = stat_d[uoe_pkg::UOE_IRQ_Y] | (pkt_done & sel_y_q);
    stat_d[uoe_pkg::UOE_IRQ_OVF] = stat_d[uoe_pkg::UOE_IRQ_OVF] | ovf_evt;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bsize_q <= uoe_pkg::UOE_RST_BYTE;
      xbase_q <= uoe_pkg::UOE_RST_BYTE;
      ybase_q <= uoe_pkg::UOE_RST_BYTE;
      cnf_q <= uoe_pkg::UOE_RST_BYTE;
      xcnt_q <= uoe_pkg::UOE_RST_BYTE;
      ycnt_q <= uoe_pkg::UOE_RST_BYTE;
      stat_q <= 3'b000;
      mask_q <= 3'b000;
    end
    else
    begin
      if (wr_bsize)
      begin
        bsize_q <= wb_byte;
      end
      if (wr_xbase)
      begin
        xbase_q <= wb_byte;
      end
      if (wr_ybase)
      begin
        ybase_q <= wb_byte;
      end
      if (wr_mask)
      begin
        mask_q <= wb_byte[2:0];
      end
      cnf_q <= cnf_d;
      xcnt_q <= xcnt_d;
      ycnt_q <= ycnt_d;
      stat_q <= stat_d;
    end
  end

  // Iso endpoints have no interrupt-enable bit, so they use the mask alone
  assign irq = |(stat_q & mask_q) & (ep_ie | ep_iso); // R13

  // ******************************
  // Read data
  // ******************************
  wire [7:0] rd_byte =
    (wb_adr_i == uoe_pkg::UOE_ADR_BSIZE) ? bsize_q :
    (wb_adr_i == uoe_pkg::UOE_ADR_XBASE) ? xbase_q :
    (wb_adr_i == uoe_pkg::UOE_ADR_CNF) ? cnf_q :
    (wb_adr_i == uoe_pkg::UOE_ADR_XCNT) ? xcnt_q :
    (wb_adr_i == uoe_pkg::UOE_ADR_YBASE) ? ybase_q :
    (wb_adr_i == uoe_pkg::UOE_ADR_YCNT) ? ycnt_q :
    (wb_adr_i == uoe_pkg::UOE_ADR_IRQ_STAT) ? {5'h00, stat_q} :
    (wb_adr_i == uoe_pkg::UOE_ADR_IRQ_MASK) ? {5'h00, mask_q} : 8'h00;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (rd_fire)
    begin
      rdata_q <= {24'h000000, rd_byte};
    end
  end

  assign wb_dat_o = rdata_q;

endmodule : uoe_out_ep

/* tb/uoe_out_ep_properties.sv */
// Purpose: Port-level properties of the OUT endpoint block
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to the top module, sees its ports only
`timescale 1ns/1ps

module uoe_out_ep_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_setup,
  input wire logic rx_valid,
  input wire logic rx_end,
  input wire logic [1:0] hs_code,
  input wire logic hs_valid,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  AST_ACK_ONE_CYCLE: assert property (s_req |=> s_answer)
    else $error("ack not one cycle after request");
  AST_ACK_DROPS: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_READ_UPPER_ZERO: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_RESET_QUIET: assert property ($fell(rst) |-> !wb_ack_o && !irq)
    else $error("ack or irq active after reset");
  AST_HS_AT_END: assert property (hs_valid |-> rx_end)
    else $error("handshake outside packet end");
  AST_SETUP_NOT_STALLED: assert property (hs_valid && rx_setup |-> hs_code != 2'h2)
    else $error("setup stage answered with stall");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> wb_ack_o || $past(rx_end || rx_valid))
    else $error("irq rose without event or register write");
endmodule : uoe_out_ep_properties

bind uoe_out_ep uoe_out_ep_properties u_props (.clk_sys, .rst, .wb_we_i, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .rx_setup, .rx_valid, .rx_end, .hs_code, .hs_valid, .irq);

/* tb/uoe_host_model.sv */
// Purpose: Host side of the packet link, sends OUT data packets
// Assumes: Called just after a rising edge
// Notes: After a packet the data, setup and PID lines show inverted values so stale data is never trusted
`timescale 1ns/1ps

module uoe_host_model (
  input wire logic clk_sys,
  output logic rx_start,
  output logic rx_setup,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_good,
  output logic rx_pid_data1,
  input wire logic [1:0] hs_code
);
  initial
  begin
    {rx_start, rx_setup, rx_valid, rx_end, rx_good, rx_pid_data1} = 6'h00;
    rx_data = 8'h00;
  end

  // Bytes are base, base+1, ...; the handshake is taken in the end cycle
  task automatic send(input int len, input logic [7:0] base, input logic pid1,
    input logic setup, output logic [1:0] hs);
    int i;
    rx_start <= 1'b1;
    rx_setup <= setup;
    @(posedge clk_sys);
    rx_start <= 1'b0;
    for (i = 0; i < len; i++)
    begin
      rx_valid <= 1'b1;
      rx_data <= base + 8'(i);
      @(posedge clk_sys);
    end
    rx_valid <= 1'b0;
    rx_end <= 1'b1;
    rx_good <= 1'b1;
    rx_pid_data1 <= pid1;
    @(negedge clk_sys);
    hs = hs_code;
    @(posedge clk_sys);
    rx_end <= 1'b0;
    rx_good <= 1'b0;
    rx_data <= ~rx_data;
    rx_setup <= ~setup;
    rx_pid_data1 <= ~pid1;
    // Idle cycle so a following call never reassigns rx_setup in this step
    @(posedge clk_sys);
  endtask : send
endmodule : uoe_host_model

/* tb/uoe_out_ep_test.sv */
// Purpose: Register and packet tests of the OUT endpoint
// Assumes: One-cycle ack, registered memory read
// Notes: Expected values derive from register settings
`timescale 1ns/1ps

module uoe_out_ep_test;
  logic clk_sys, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, hs_valid, irq;
  logic rx_start, rx_setup, rx_valid, rx_end, rx_good, rx_pid_data1;
  logic [7:0] wb_adr_i, rx_data, fw_rd_data;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic [1:0] hs_code;
  logic [10:0] fw_rd_addr;
  int errors = 0;
  int n_checks = 0;
  logic [7:0] n_hs = 8'h00;
  localparam logic [1:0] ACK = 2'h0, NAK = 2'h1, STL = 2'h2, NON = 2'h3;

  uoe_out_ep u_dut (.clk_sys, .rst, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .rx_start, .rx_setup, .rx_valid,
    .rx_data, .rx_end, .rx_good, .rx_pid_data1, .hs_code, .hs_valid,
    .fw_rd_addr, .fw_rd_data, .irq);
  uoe_host_model u_host (.clk_sys, .rx_start, .rx_setup, .rx_valid, .rx_data,
    .rx_end, .rx_good, .rx_pid_data1, .hs_code);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wb(input logic [7:0] adr, input logic we, input logic [7:0] d,
    output logic [7:0] q);
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= {24'h000000, d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // Ack and read data are taken at one rising edge; the watchdog ends a hang
    do
    begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] q;
    wb(adr, 1'b1, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] q;
    wb(adr, 1'b0, 8'h00, q);
    chk($sformatf("reg %h", adr), exp, q);
  endtask : rdc

  task automatic mem(input logic [10:0] a, input logic [7:0] exp);
    fw_rd_addr <= a;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk($sformatf("mem %h", a), exp, fw_rd_data);
    @(posedge clk_sys);
  endtask : mem

  task automatic pk(input int len, input logic [7:0] base, input logic pid1,
    input logic setup, input logic [1:0] exp);
    logic [1:0] hs;
    u_host.send(len, base, pid1, setup, hs);
    chk("handshake", {6'h00, exp}, {6'h00, hs});
  endtask : pk

  initial
  begin
    #100000;
    errors++;
    close_out();
  end

  // Counts handshake pulses, one per non-iso packet end
  always @(posedge clk_sys)
    if (hs_valid === 1'b1)
      n_hs <= n_hs + 8'h01;

  initial
  begin
    {wb_we_i, wb_cyc_i, wb_stb_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h00000000;
    wb_sel_i = 4'hF;
    fw_rd_addr = 11'h000;
    rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int a = 0; a <= 8'h20; a += 4)
      rdc(8'(a), 8'h00);
    pk(2, 8'h10, 1'b0, 1'b0, NON);
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h12);
    wr(8'h10, 8'h13);
    wr(8'h1C, 8'h07);
    wr(8'h08, 8'h84);
    pk(3, 8'hA0, 1'b0, 1'b0, ACK);
    chk("irq", 8'h01, {7'h00, irq});
    mem(11'h090, 8'hA0);
    mem(11'h092, 8'hA2);
    rdc(8'h0C, 8'h83);
    rdc(8'h08, 8'hA4);
    rdc(8'h18, 8'h01);
    chk("irq", 8'h00, {7'h00, irq});
    pk(3, 8'hA8, 1'b1, 1'b0, NAK);
    wr(8'h0C, 8'h00);
    pk(3, 8'hA8, 1'b0, 1'b0, NON);
    rdc(8'h08, 8'hA4);
    wr(8'h08, 8'hB4);
    pk(3, 8'hB0, 1'b1, 1'b0, ACK);
    pk(3, 8'hC0, 1'b0, 1'b0, ACK);
    mem(11'h098, 8'hC0);
    wr(8'h0C, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h08, 8'h84);
    pk(10, 8'hD0, 1'b0, 1'b0, ACK);
    mem(11'h097, 8'hD7);
    mem(11'h098, 8'hC0);
    rdc(8'h18, 8'h07);
    wr(8'h0C, 8'h00);
    wr(8'h08, 8'h8C);
    pk(2, 8'h20, 1'b0, 1'b0, STL);
    pk(2, 8'h20, 1'b0, 1'b1, ACK);
    wr(8'h08, 8'hC0);
    wr(8'h00, 8'h01);
    pk(10, 8'hE0, 1'b0, 1'b0, ACK);
    mem(11'h090, 8'hE8);
    mem(11'h092, 8'hE2);
    rdc(8'h08, 8'hE0);
    chk("hs pulses", 8'h09, n_hs);
    close_out();
  end
endmodule : uoe_out_ep_test
